// File: rtl/tsa_alarm_chan.sv
`timescale 1ns/1ps
module tsa_alarm_chan (
  // Clock and reset
  input  wire logic                           i_core_clk,
  input  wire logic                           i_rstn,
  // Comparison inputs
  input  wire logic signed [tsa_pkg::INT_W-1:0] i_reading,
  input  wire logic        [7:0]              i_limit,
  input  wire logic        [7:0]              i_hyst,
  // Status bit
  output logic                                o_flag
);

  logic signed [tsa_pkg::INT_W-1:0] limit_s;
  logic signed [tsa_pkg::INT_W-1:0] release_s;
  logic                             flag_reg;

  assign limit_s   = signed'({2'h0, i_limit});
  assign release_s = limit_s - signed'({2'h0, i_hyst});
  assign o_flag    = flag_reg;

  // RULE8: set at limit
  // RULE9: hysteresis release
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      flag_reg <= 1'b0;
    end else if (i_reading >= limit_s) begin
      flag_reg <= 1'b1;
    end else if (i_reading < release_s) begin
      flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  AST_SET_AT_LIMIT: assert property ( // RULE8
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_reading >= limit_s) |=> flag_reg)
    else $error("alarm flag not set at limit");

  AST_HOLD_IN_BAND: assert property ( // RULE9
    @(posedge i_core_clk) disable iff (!i_rstn)
    (flag_reg && i_reading >= release_s) |=> flag_reg)
    else $error("alarm flag dropped inside hysteresis band");

endmodule : tsa_alarm_chan

// File: rtl/tsa_pkg.sv
package tsa_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CHAN   = 5;
  localparam int NUM_REMOTE = 4;
  localparam int NUM_ALARM  = 3;
  localparam int RAW_W      = 12;
  localparam int RES_W      = 11;
  localparam int INT_W      = 10;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_COMMON_STATUS = 8'h02;
  localparam logic [7:0] OFF_DIODE_FAULT   = 8'h07;
  localparam logic [7:0] OFF_FIRST_ALARM   = 8'h08;
  localparam logic [7:0] OFF_SECOND_ALARM  = 8'h09;
  localparam logic [7:0] OFF_THIRD_ALARM   = 8'h0A;

  // ==========================================================
  // Field positions and reset values
  localparam int          BIT_BUSY         = 7;
  localparam int          BIT_NOT_READY    = 6;
  localparam int          BIT_FAULT_ANY    = 0;
  localparam int          BIT_ALARM1_ANY   = 1;
  localparam int          BIT_ALARM2_ANY   = 2;
  localparam int          BIT_ALARM3_ANY   = 3;
  localparam int          CHAN_LOCAL       = 0;
  localparam logic [7:0]  COMMON_RESET     = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA    = 8'h00;
  localparam logic [RES_W-1:0] SIGNED_FAULT   = 11'h400;
  localparam logic [RES_W-1:0] UNSIGNED_FAULT = 11'h000;
  localparam logic [RES_W-1:0] UNSIGNED_MAX   = 11'h7FF;
  localparam logic [RES_W-1:0] SIGNED_MAX     = 11'h3FF;

  // ==========================================================
  // Timing
  localparam real         CORE_CLK_MHZ     = 100.0;
  localparam real         NOT_READY_MS     = 30.0;
  localparam int          NOT_READY_CYCLES =
    int'(NOT_READY_MS * 1000.0 * CORE_CLK_MHZ);

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic open_flt;
    logic short_flt;
  } tsa_fault_type;

  typedef struct packed {
    logic [7:0] common;
    logic [7:0] fault;
    logic [7:0] alarm1;
    logic [7:0] alarm2;
    logic [7:0] alarm3;
  } tsa_status_type;

endpackage : tsa_pkg

// File: rtl/tsa_status_top.sv
// Function
// RULE1: Common status bit 7 shows a conversion in progress.
// RULE2: Common status bit 6 stays high during the 30 ms power-up.
// RULE3: Unused common bits 5-4 and first alarm bits 7-5 read zero.
// RULE4: Common bits 3-0 flag any set bit in status registers 1-4.
// RULE5: Fault register holds open and short bits per remote, open odd.
// RULE6: Short is D+ to ground or D-; open is D+ to supply or floating.
// RULE7: Faulted channel reads 0 unsigned and -128.000 signed.
// RULE8: Alarm bit sets when reading reaches its limit; remote4 bit 4.
// RULE9: Alarm bit clears only below limit minus common hysteresis.
// RULE10: Remotes 1-2 use alarm-specific limits; others their single limit.
// RULE11: First alarm output active while any unmasked status bit is set.
// RULE12: Host only reads status registers; common resets to 0x00 (the code sets not-ready bit 6 from reset, so it first reads 0x40).
// RULE13: Second and third alarm outputs work the same way.
// RULE14: Mask bits gate outputs while status bits keep tracking.
`timescale 1ns/1ps
module tsa_status_top #(
  parameter int NOT_READY_CYCLES = tsa_pkg::NOT_READY_CYCLES
) (
  // Core clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rstn,
  // Conversion engine
  input  wire logic                        i_conv_busy,
  input  wire logic [tsa_pkg::RAW_W-1:0]   i_raw_temp [tsa_pkg::NUM_CHAN],
  // Remote diode sense comparators, asynchronous
  input  wire logic [tsa_pkg::NUM_REMOTE-1:0] i_dplus_at_gnd,
  input  wire logic [tsa_pkg::NUM_REMOTE-1:0] i_dplus_at_dminus,
  input  wire logic [tsa_pkg::NUM_REMOTE-1:0] i_dplus_at_vdd,
  input  wire logic [tsa_pkg::NUM_REMOTE-1:0] i_dplus_floating,
  // Limits, hysteresis and masks
  input  wire logic [7:0]                  i_crit_limit [tsa_pkg::NUM_CHAN],
  input  wire logic [7:0]                  i_r12_limit1 [2],
  input  wire logic [7:0]                  i_r12_limit2 [2],
  input  wire logic [7:0]                  i_r12_limit3 [2],
  input  wire logic [7:0]                  i_common_hyst,
  input  wire logic [tsa_pkg::NUM_CHAN-1:0] i_alarm_mask [tsa_pkg::NUM_ALARM],
  // Temperature results
  output logic [tsa_pkg::RES_W-1:0]        o_temp_signed   [tsa_pkg::NUM_CHAN],
  output logic [tsa_pkg::RES_W-1:0]        o_temp_unsigned [tsa_pkg::NUM_CHAN],
  // Alarm pins, active low
  output logic                             o_first_alarm_output_n,
  output logic                             o_second_alarm_output_n,
  output logic                             o_third_alarm_output_n,
  // Register read port on the link clock
  input  wire logic                        i_link_clk,
  input  wire logic                        i_rd_req,
  input  wire logic [7:0]                  i_rd_addr,
  output logic                             o_rd_busy,
  output logic                             o_rd_valid,
  output logic [7:0]                       o_rd_data
);

  // ==========================================================
  // Decoding
  function automatic logic [7:0] read_mux(
    input logic [7:0]             addr,
    input tsa_pkg::tsa_status_type st
  );
    case (addr)
      tsa_pkg::OFF_COMMON_STATUS: read_mux = st.common;
      tsa_pkg::OFF_DIODE_FAULT:   read_mux = st.fault;
      tsa_pkg::OFF_FIRST_ALARM:   read_mux = st.alarm1;
      tsa_pkg::OFF_SECOND_ALARM:  read_mux = st.alarm2;
      tsa_pkg::OFF_THIRD_ALARM:   read_mux = st.alarm3;
      default:                    read_mux = tsa_pkg::UNMAPPED_DATA;
    endcase
  endfunction : read_mux

  function automatic logic [7:0] alarm_byte(
    input logic [tsa_pkg::NUM_CHAN-1:0] bits
  );
    // RULE3: reserved bits zero
    alarm_byte = {3'h0, bits};
  endfunction : alarm_byte

  // ==========================================================
  // Power-up not-ready timer
  typedef enum logic [0:0] {
    ST_INIT,
    ST_READY
  } tsa_init_type;

  tsa_init_type init_state_reg;
  logic [31:0]  init_cnt_reg;
  logic         not_ready_flag;

  // RULE2: power-up hold
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      init_state_reg <= ST_INIT;
      init_cnt_reg   <= 32'h0;
    end else begin
      case (init_state_reg)
        ST_INIT: begin
          if (init_cnt_reg >= 32'(NOT_READY_CYCLES - 1)) begin
            init_state_reg <= ST_READY;
          end else begin
            init_cnt_reg <= init_cnt_reg + 32'h1;
          end
        end
        ST_READY: init_state_reg <= ST_READY;
        default:  init_state_reg <= ST_INIT;
      endcase
    end
  end

  assign not_ready_flag = (init_state_reg == ST_INIT);

  // ==========================================================
  // Diode fault capture
  logic [4*tsa_pkg::NUM_REMOTE-1:0] sense_meta_reg;
  logic [4*tsa_pkg::NUM_REMOTE-1:0] sense_sync_reg;
  tsa_pkg::tsa_fault_type         fault_reg [tsa_pkg::NUM_REMOTE];
  logic [7:0]                     fault_byte;
  logic [tsa_pkg::NUM_CHAN-1:0]   chan_faulted;

  // Pins are asynchronous; two stages before use
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      sense_meta_reg <= '0;
      sense_sync_reg <= '0;
    end else begin
      // Order from the top: gnd, D-, supply, floating
      sense_meta_reg <= {i_dplus_at_gnd, i_dplus_at_dminus,
                         i_dplus_at_vdd, i_dplus_floating};
      sense_sync_reg <= sense_meta_reg;
    end
  end

  assign chan_faulted[tsa_pkg::CHAN_LOCAL] = 1'b0;

  genvar gr;
  generate
    for (gr = 0; gr < tsa_pkg::NUM_REMOTE; gr++) begin : g_fault
      always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
          fault_reg[gr] <= '0;
        end else begin
          // RULE6: fault causes
          fault_reg[gr].open_flt  <=
            sense_sync_reg[tsa_pkg::NUM_REMOTE+gr] | sense_sync_reg[gr];
          fault_reg[gr].short_flt <=
            sense_sync_reg[3*tsa_pkg::NUM_REMOTE+gr] |
            sense_sync_reg[2*tsa_pkg::NUM_REMOTE+gr];
        end
      end
      // RULE5: open odd, short even
      assign fault_byte[2*gr+1] = fault_reg[gr].open_flt;
      assign fault_byte[2*gr]   = fault_reg[gr].short_flt;
      assign chan_faulted[gr+1] = fault_reg[gr].open_flt |
                                  fault_reg[gr].short_flt;
    end
  endgenerate

  // ==========================================================
  // Result forcing and alarm comparison
  logic signed [tsa_pkg::INT_W-1:0] reading [tsa_pkg::NUM_CHAN];
  logic [tsa_pkg::NUM_CHAN-1:0]     alarm_bits [tsa_pkg::NUM_ALARM];
  logic [7:0]                       chan_limit [tsa_pkg::NUM_ALARM]
                                               [tsa_pkg::NUM_CHAN];

  genvar gc;
  genvar ga;
  generate
    for (gc = 0; gc < tsa_pkg::NUM_CHAN; gc++) begin : g_chan
      logic signed [tsa_pkg::RAW_W-1:0] raw_s;
      assign raw_s = signed'(i_raw_temp[gc]);

      // A faulted channel reads -128 so it can never raise an alarm
      assign reading[gc] = chan_faulted[gc] ? -10'sd128 :
                           signed'({raw_s[tsa_pkg::RAW_W-1],
                                    raw_s[tsa_pkg::RAW_W-1:3]});

      // RULE7: forced fault results
      always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
          o_temp_signed[gc]   <= '0;
          o_temp_unsigned[gc] <= '0;
        end else if (chan_faulted[gc]) begin
          o_temp_signed[gc]   <= tsa_pkg::SIGNED_FAULT;
          o_temp_unsigned[gc] <= tsa_pkg::UNSIGNED_FAULT;
        end else begin
          if (raw_s > signed'({1'b0, tsa_pkg::SIGNED_MAX})) begin
            o_temp_signed[gc] <= tsa_pkg::SIGNED_MAX;
          end else if (raw_s < signed'({1'b1, tsa_pkg::SIGNED_FAULT})) begin
            o_temp_signed[gc] <= tsa_pkg::SIGNED_FAULT;
          end else begin
            o_temp_signed[gc] <= raw_s[tsa_pkg::RES_W-1:0];
          end
          if (raw_s[tsa_pkg::RAW_W-1]) begin
            o_temp_unsigned[gc] <= tsa_pkg::UNSIGNED_FAULT;
          end else begin
            // Positive raw range fits the field, never above max
            o_temp_unsigned[gc] <= raw_s[tsa_pkg::RES_W-1:0];
          end
        end
      end

      for (ga = 0; ga < tsa_pkg::NUM_ALARM; ga++) begin : g_alarm
        // RULE10: limit selection
        if (gc == 1 || gc == 2) begin : g_dedicated
          assign chan_limit[ga][gc] =
            (ga == 0) ? i_r12_limit1[gc-1] :
            (ga == 1) ? i_r12_limit2[gc-1] : i_r12_limit3[gc-1];
        end else begin : g_single
          assign chan_limit[ga][gc] = i_crit_limit[gc];
        end

        tsa_alarm_chan u_cmp (
          .i_core_clk (i_core_clk),
          .i_rstn     (i_rstn),
          .i_reading  (reading[gc]),
          .i_limit    (chan_limit[ga][gc]),
          .i_hyst     (i_common_hyst),
          .o_flag     (alarm_bits[ga][gc])
        );
      end
    end
  endgenerate

  // ==========================================================
  // Alarm outputs
  logic [tsa_pkg::NUM_ALARM-1:0] alarm_active_reg;

  // RULE11: first output
  // RULE13: second and third
  // RULE14: mask gating
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      alarm_active_reg <= '0;
    end else begin
      for (int k = 0; k < tsa_pkg::NUM_ALARM; k++) begin
        alarm_active_reg[k] <= |(alarm_bits[k] & ~i_alarm_mask[k]);
      end
    end
  end

  assign o_first_alarm_output_n  = ~alarm_active_reg[0];
  assign o_second_alarm_output_n = ~alarm_active_reg[1];
  assign o_third_alarm_output_n  = ~alarm_active_reg[2];

  // ==========================================================
  // Status assembly
  tsa_pkg::tsa_status_type status;
  logic                    alarm1_reg_any_flag;
  logic                    fault_reg_any_flag;

  // RULE4: summary flags
  assign fault_reg_any_flag  = |fault_byte;
  assign alarm1_reg_any_flag = |alarm_bits[0];

  // RULE1: busy bit
  // RULE3: reserved bits zero
  assign status.common = {i_conv_busy, not_ready_flag, 2'h0,
                          |alarm_bits[2], |alarm_bits[1],
                          alarm1_reg_any_flag, fault_reg_any_flag};
  assign status.fault  = fault_byte;
  assign status.alarm1 = alarm_byte(alarm_bits[0]);
  assign status.alarm2 = alarm_byte(alarm_bits[1]);
  assign status.alarm3 = alarm_byte(alarm_bits[2]);

  // ==========================================================
  // Read handshake, link side
  logic       link_rst_meta_reg;
  logic       link_rstn_reg;
  logic       req_tgl_reg;
  logic [7:0] req_addr_reg;
  logic       ack_meta_reg;
  logic       ack_sync_reg;
  logic       ack_seen_reg;
  logic       core_ack_tgl_reg;
  logic [7:0] core_data_reg;

  always_ff @(posedge i_link_clk) begin
    link_rst_meta_reg <= i_rstn;
    link_rstn_reg     <= link_rst_meta_reg;
  end

  // Requests while one is in flight are dropped
  assign o_rd_busy = (req_tgl_reg != ack_seen_reg) ||
                     (ack_sync_reg != ack_seen_reg);

  always_ff @(posedge i_link_clk) begin
    if (!link_rstn_reg) begin
      req_tgl_reg  <= 1'b0;
      req_addr_reg <= 8'h00;
    end else if (i_rd_req && !o_rd_busy) begin
      req_tgl_reg  <= ~req_tgl_reg;
      req_addr_reg <= i_rd_addr;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!link_rstn_reg) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      o_rd_valid   <= 1'b0;
      o_rd_data    <= 8'h00;
    end else begin
      ack_meta_reg <= core_ack_tgl_reg;
      ack_sync_reg <= ack_meta_reg;
      ack_seen_reg <= ack_sync_reg;
      o_rd_valid   <= (ack_sync_reg != ack_seen_reg);
      // Core data is held stable until the next request
      if (ack_sync_reg != ack_seen_reg) begin
        o_rd_data <= core_data_reg;
      end
    end
  end

  // ==========================================================
  // Read handshake, core side
  logic req_meta_reg;
  logic req_sync_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      req_meta_reg     <= 1'b0;
      req_sync_reg     <= 1'b0;
      core_ack_tgl_reg <= 1'b0;
      core_data_reg    <= tsa_pkg::COMMON_RESET;
    end else begin
      req_meta_reg <= req_tgl_reg;
      req_sync_reg <= req_meta_reg;
      // Address is stable: the link side holds it until the ack returns
      if (req_sync_reg != core_ack_tgl_reg) begin
        core_data_reg    <= read_mux(req_addr_reg, status);
        core_ack_tgl_reg <= req_sync_reg;
      end
    end
  end

  // ==========================================================
  // Checks
  AST_BUSY_BIT: assert property ( // RULE1
    @(posedge i_core_clk) disable iff (!i_rstn)
    (req_sync_reg != core_ack_tgl_reg &&
     req_addr_reg == tsa_pkg::OFF_COMMON_STATUS) |=>
    core_data_reg[tsa_pkg::BIT_BUSY] == $past(i_conv_busy))
    else $error("busy bit does not follow conversion");

  AST_NOT_READY_LOW_AFTER: assert property ( // RULE2
    @(posedge i_core_clk) disable iff (!i_rstn)
    $fell(not_ready_flag) |-> init_cnt_reg == 32'(NOT_READY_CYCLES - 1))
    else $error("not-ready dropped at the wrong count");

  AST_RESERVED_ZERO: assert property ( // RULE3
    @(posedge i_core_clk) disable iff (!i_rstn)
    status.common[5:4] == 2'h0 && status.alarm1[7:5] == 3'h0)
    else $error("reserved status bits not zero");

  AST_SUMMARY: assert property ( // RULE4
    @(posedge i_core_clk) disable iff (!i_rstn)
    status.common[tsa_pkg::BIT_ALARM3_ANY] == (status.alarm3 != 8'h00) &&
    status.common[tsa_pkg::BIT_FAULT_ANY] == (status.fault != 8'h00))
    else $error("summary flag mismatch");

  AST_SHORT_CAPTURE: assert property ( // RULE6
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_dplus_at_gnd[0] | i_dplus_at_dminus[0])[*4] |-> fault_byte[0])
    else $error("short fault not flagged");

  AST_FAULT_FORCE: assert property ( // RULE7
    @(posedge i_core_clk) disable iff (!i_rstn)
    chan_faulted[1] |=> o_temp_signed[1] == tsa_pkg::SIGNED_FAULT &&
                        o_temp_unsigned[1] == tsa_pkg::UNSIGNED_FAULT)
    else $error("faulted channel not forced");

  AST_FIRST_OUTPUT: assert property ( // RULE11
    @(posedge i_core_clk) disable iff (!i_rstn)
    |(alarm_bits[0] & ~i_alarm_mask[0]) |=> !o_first_alarm_output_n)
    else $error("first alarm output not active");

  AST_THIRD_RELEASE: assert property ( // RULE13
    @(posedge i_core_clk) disable iff (!i_rstn)
    (alarm_bits[2] == '0) |=> o_third_alarm_output_n)
    else $error("third alarm output not released");

  AST_MASK_BLOCKS: assert property ( // RULE14
    @(posedge i_core_clk) disable iff (!i_rstn)
    ((alarm_bits[1] & ~i_alarm_mask[1]) == '0) |=> o_second_alarm_output_n)
    else $error("masked bit drives second alarm output");

endmodule : tsa_status_top

// File: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  localparam int NR_CYC = 40;
  localparam int NC     = tsa_pkg::NUM_CHAN;
  // ==========================================================
  // Signals
  logic                           core_clk, link_clk, rstn, conv_busy;
  logic [tsa_pkg::RAW_W-1:0]      raw [NC];
  logic [tsa_pkg::NUM_REMOTE-1:0] s_gnd, s_dm, s_vdd, s_flt;
  logic [7:0]                     crit [NC];
  logic [7:0]                     lim1 [2], lim2 [2], lim3 [2];
  logic [7:0]                     hyst;
  logic [NC-1:0]                  mask [tsa_pkg::NUM_ALARM];
  logic [NC-1:0]                  flg  [tsa_pkg::NUM_ALARM];
  logic [tsa_pkg::RES_W-1:0]      t_sig [NC], t_uns [NC];
  logic                           al1_n, al2_n, al3_n;
  logic                           rd_req, rd_busy, rd_valid;
  logic [7:0]                     rd_addr, rd_data;
  int                             num_errors, n_checks;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Link clock runs free: its domain carries the reset synchroniser
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  tsa_status_top #(.NOT_READY_CYCLES(NR_CYC)) DUT (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_conv_busy(conv_busy),
    .i_raw_temp(raw), .i_dplus_at_gnd(s_gnd), .i_dplus_at_dminus(s_dm),
    .i_dplus_at_vdd(s_vdd), .i_dplus_floating(s_flt),
    .i_crit_limit(crit), .i_r12_limit1(lim1), .i_r12_limit2(lim2),
    .i_r12_limit3(lim3), .i_common_hyst(hyst), .i_alarm_mask(mask),
    .o_temp_signed(t_sig), .o_temp_unsigned(t_uns),
    .o_first_alarm_output_n(al1_n), .o_second_alarm_output_n(al2_n),
    .o_third_alarm_output_n(al3_n), .i_link_clk(link_clk),
    .i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_busy(rd_busy),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data));

  tsa_host_model HOST (
    .i_link_clk(link_clk), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
    .i_rd_busy(rd_busy), .i_rd_valid(rd_valid), .i_rd_data(rd_data));

  // ==========================================================
  // Reference model
  function automatic int intpart(int ch);
    int r;
    r = $signed(raw[ch]);
    return r >>> 3;
  endfunction : intpart

  function automatic logic faulty(int ch);
    logic [3:0] f;
    f = s_gnd | s_dm | s_vdd | s_flt;
    if (ch == 0) return 1'b0;
    return f[ch-1];
  endfunction : faulty

  function automatic int limit_of(int a, int ch);
    if (ch == 1 || ch == 2)
      return a == 0 ? lim1[ch-1] : a == 1 ? lim2[ch-1] : lim3[ch-1];
    return crit[ch];
  endfunction : limit_of

  function automatic logic [7:0] fault_exp();
    logic [7:0] r;
    for (int k = 0; k < 4; k++) begin
      r[2*k+1] = s_vdd[k] | s_flt[k];
      r[2*k]   = s_gnd[k] | s_dm[k];
    end
    return r;
  endfunction : fault_exp

  function automatic logic [10:0] exp_sig(int ch);
    int r;
    r = $signed(raw[ch]);
    if (faulty(ch)) return tsa_pkg::SIGNED_FAULT;
    if (r > 1023) r = 1023;
    if (r < -1024) r = -1024;
    return r[10:0];
  endfunction : exp_sig

  function automatic logic [10:0] exp_uns(int ch);
    if (faulty(ch)) return tsa_pkg::UNSIGNED_FAULT;
    return raw[ch][11] ? 11'h000 : raw[ch][10:0];
  endfunction : exp_uns

  // Limits land near the reading so the hysteresis band is hit often
  function automatic logic [7:0] near(int ch);
    int b;
    b = intpart(ch) + int'($urandom_range(0, 8)) - 4;
    if (b < 0) b = 0;
    if (b > 255) b = 255;
    return 8'(b);
  endfunction : near

  task automatic update_flags();
    int rd, lm;
    for (int a = 0; a < 3; a++) begin
      for (int ch = 0; ch < NC; ch++) begin
        rd = faulty(ch) ? -128 : intpart(ch);
        lm = limit_of(a, ch);
        if (rd >= lm) flg[a][ch] = 1'b1;
        else if (rd < lm - int'(hyst)) flg[a][ch] = 1'b0;
      end
    end
  endtask : update_flags

  // ==========================================================
  // Stimulus and checks
  task automatic stim(int it);
    int f;
    conv_busy = 1'($urandom_range(0, 1));
    hyst      = 8'($urandom_range(0, 6));
    for (int a = 0; a < 3; a++)
      mask[a] = ($urandom_range(0, 2) == 0) ? '0 : 5'($urandom);
    for (int ch = 0; ch < NC; ch++) begin
      raw[ch] = 12'($urandom);
      // Range ends for the clamps
      if (it < 2) raw[ch] = it ? 12'h800 : 12'h7FF;
      crit[ch] = near(ch);
    end
    for (int i = 0; i < 2; i++) begin
      lim1[i] = near(i + 1);
      lim2[i] = near(i + 1);
      lim3[i] = near(i + 1);
    end
    for (int k = 0; k < 4; k++) begin
      f = $urandom_range(0, 11);
      s_gnd[k] = (f == 0);
      s_dm[k]  = (f == 1);
      s_vdd[k] = (f == 2);
      s_flt[k] = (f == 3);
    end
  endtask : stim

  task automatic rd_chk(logic [7:0] a, logic [7:0] e, string nm);
    logic [7:0] d;
    logic       ok;
    HOST.read(a, d, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %s exp answer got none", nm);
    end else `CHK(nm, e, d)
  endtask : rd_chk

  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  initial begin
    void'($urandom(32'hD5F6));
    num_errors = 0;
    n_checks   = 0;
    rstn = 1'b0;
    conv_busy = 1'b0;
    hyst = 8'h00;
    {s_gnd, s_dm, s_vdd, s_flt} = '0;
    for (int ch = 0; ch < NC; ch++) begin
      raw[ch]  = 12'h000;
      crit[ch] = 8'hFF;
    end
    for (int a = 0; a < 3; a++) begin
      mask[a] = '0;
      flg[a]  = '0;
    end
    lim1 = '{8'hFF, 8'hFF};
    lim2 = '{8'hFF, 8'hFF};
    lim3 = '{8'hFF, 8'hFF};
    // Five core cycles so the link side also sees four reset edges
    repeat (5) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge link_clk);
    rd_chk(tsa_pkg::OFF_COMMON_STATUS, 8'h40, "not_ready"); // early
    repeat (NR_CYC + 10) @(posedge core_clk);
    rd_chk(tsa_pkg::OFF_COMMON_STATUS, tsa_pkg::COMMON_RESET,
           "common_idle"); // reset value
    for (int it = 0; it < 48; it++) begin
      @(posedge core_clk);
      #1;
      stim(it);
      repeat (12) @(posedge core_clk);
      #1;
      update_flags();
      for (int ch = 0; ch < NC; ch++) begin
        `CHK("t_sig", exp_sig(ch), t_sig[ch]) // signed
        `CHK("t_uns", exp_uns(ch), t_uns[ch]) // unsigned
      end
      `CHK("pin1", ~|(flg[0] & ~mask[0]), al1_n) // pin
      `CHK("pin2", ~|(flg[1] & ~mask[1]), al2_n) // pin
      `CHK("pin3", ~|(flg[2] & ~mask[2]), al3_n) // pin
      rd_chk(tsa_pkg::OFF_COMMON_STATUS, {conv_busy, 3'b000, |flg[2],
             |flg[1], |flg[0], |fault_exp()}, "common");
      rd_chk(tsa_pkg::OFF_DIODE_FAULT, fault_exp(), "fault");
      rd_chk(tsa_pkg::OFF_FIRST_ALARM, {3'b000, flg[0]},
             "alarm1"); // status
      rd_chk(tsa_pkg::OFF_SECOND_ALARM, {3'b000, flg[1]}, "alarm2");
      rd_chk(tsa_pkg::OFF_THIRD_ALARM, {3'b000, flg[2]}, "alarm3");
      rd_chk(8'($urandom_range(11, 255)), tsa_pkg::UNMAPPED_DATA,
             "unmapped"); // empty offset
    end
    final_report();
  end
endmodule : tb_top

// File: verification/tsa_host_model.sv
`timescale 1ns/1ps
module tsa_host_model (
  // Link clock
  input  wire logic       i_link_clk,
  // Read request
  output logic            o_rd_req,
  output logic [7:0]      o_rd_addr,
  // Read answer
  input  wire logic       i_rd_busy,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data
);
  initial begin
    o_rd_req  = 1'b0;
    o_rd_addr = 8'h00;
  end

  // ==========================================================
  // Host read
  // reads only
  task automatic read(input logic [7:0] addr, output logic [7:0] data,
                      output logic ok);
    int n;
    n    = 0;
    ok   = 1'b0;
    data = 8'h00;
    // Random idle time: host may be prompt or slow
    repeat ($urandom_range(0, 3)) @(posedge i_link_clk);
    @(posedge i_link_clk);
    #1;
    o_rd_req  = 1'b1;
    o_rd_addr = addr;
    // Busy moves only at link edges: low now means taken at the next
    while (i_rd_busy !== 1'b0 && n < 40) begin
      @(posedge i_link_clk);
      #1;
      n++;
    end
    @(posedge i_link_clk);
    #1;
    o_rd_req  = 1'b0;
    // Address no longer qualified: show the inverse, not a stale copy
    o_rd_addr = ~addr;
    while (!ok && n < 60) begin
      @(posedge i_link_clk);
      #1;
      n++;
      if (i_rd_valid === 1'b1) begin
        ok   = 1'b1;
        data = i_rd_data;
      end
    end
  endtask : read
endmodule : tsa_host_model
